/* patch_breakpoint_unit.v */
// Purpose: Flash patch and hardware breakpoint unit with APB registers
// Assumes: Core fetch and literal requests arrive on clk, one per cycle at most
// Notes: Results come one cycle after the request, alongside the flash access
`timescale 1ns/1ps
`default_nettype none
`include "patch_breakpoint_unit_consts.vh"

module patch_breakpoint_unit #(
  parameter N_INSTR = 6, // Instruction comparators
  parameter N_LIT = 2, // Literal comparators
  parameter [15:0] BKPT_OPCODE = 16'h0000 // Arbitrary breakpoint encoding
) (
  input wire clk, // Core clock, 125 MHz
  input wire rst_b, // Async reset, active low
  input wire psel, // APB select
  input wire penable, // APB access phase
  input wire pwrite, // APB write
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output wire pready, // APB ready, always high
  output reg [31:0] prdata, // APB read data
  output reg pslverr, // APB error on unmapped offset
  input wire fetch_valid, // Instruction fetch request
  input wire [31:0] fetch_addr, // Instruction fetch address
  input wire lit_valid, // Literal load request
  input wire [31:0] lit_addr, // Literal load address
  input wire [1:0] lit_size, // Literal load size
  output reg fetch_remap, // Fetch redirected to RAM
  output reg fetch_bkpt, // Fetch answered with breakpoint
  output reg fetch_discard, // Drop original flash fetch
  output reg [31:0] fetch_new_addr, // Redirected fetch address
  output reg [15:0] fetch_bkpt_instr, // Breakpoint instruction returned
  output reg [31:0] fetch_prot_addr, // Address for protection check
  output reg lit_remap, // Literal redirected to RAM
  output reg lit_discard, // Drop original flash load
  output reg [31:0] lit_new_addr, // Redirected literal address
  output reg [31:0] lit_prot_addr // Address for protection check
);

  localparam N_COMP = N_INSTR + N_LIT;

  reg [31:0] ctrl_q;
  reg [31:0] remap_q;
  reg [31:0] comp_q [0:N_COMP-1];
  reg [3:0] last_idx_q;
  reg last_bkpt_q;
  reg last_any_q;
  wire [N_COMP-1:0] hit;
  wire lit_unaligned;
  wire wr_acc;
  wire rd_setup;
  wire comp_sel;
  wire [2:0] comp_idx;
  reg fetch_hit_any;
  reg [2:0] fetch_idx;
  reg fetch_is_bkpt;
  reg lit_hit_any;
  reg [2:0] lit_idx;
  reg [31:0] rd_mux;
  reg rd_err;
  integer i;
  // Separate loop index so the reset loop does not share a driver with the priority search
  integer k;

  assign lit_unaligned = ((lit_size == `PBU_SIZE_HALF) && lit_addr[0]) ||
                         ((lit_size == `PBU_SIZE_WORD) && (lit_addr[1:0] != 2'h0)) ||
                         (lit_size == 2'h3);

  // Eight comparators, instruction first then literal
  genvar g;
  generate
    for (g = 0; g < N_COMP; g = g + 1) begin : g_comp
      if (g < N_INSTR) begin : g_instr
        patch_compare u_cmp (
          .global_en(ctrl_q[`PBU_CTRL_GEN_BIT]),
          .cfg(comp_q[g]),
          .probe_addr(fetch_addr),
          .probe_valid(fetch_valid),
          .hit(hit[g])
        );
      end else begin : g_lit
        patch_compare u_cmp (
          .global_en(ctrl_q[`PBU_CTRL_GEN_BIT]),
          .cfg(comp_q[g]),
          .probe_addr(lit_addr),
          .probe_valid(lit_valid & ~lit_unaligned),
          .hit(hit[g])
        );
      end
    end
  endgenerate

  // Lowest-numbered matching comparator wins
  always @* begin
    fetch_hit_any = 1'b0;
    fetch_idx = 3'h0;
    fetch_is_bkpt = 1'b0;
    lit_hit_any = 1'b0;
    lit_idx = 3'h0;
    for (i = N_INSTR - 1; i >= 0; i = i - 1) begin
      if (hit[i]) begin
        fetch_hit_any = 1'b1;
        fetch_idx = i[2:0];
        fetch_is_bkpt = comp_q[i][`PBU_COMP_BKPT_BIT];
      end
    end
    for (i = N_COMP - 1; i >= N_INSTR; i = i - 1) begin
      if (hit[i]) begin
        lit_hit_any = 1'b1;
        lit_idx = i[2:0];
      end
    end
  end

  // Fetch and literal results, one cycle after the request
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fetch_remap <= 1'b0;
      fetch_bkpt <= 1'b0;
      fetch_discard <= 1'b0;
      fetch_new_addr <= 32'h00000000;
      fetch_bkpt_instr <= 16'h0000;
      fetch_prot_addr <= 32'h00000000;
      lit_remap <= 1'b0;
      lit_discard <= 1'b0;
      lit_new_addr <= 32'h00000000;
      lit_prot_addr <= 32'h00000000;
    end else begin
      fetch_remap <= fetch_hit_any & ~fetch_is_bkpt;
      fetch_bkpt <= fetch_hit_any & fetch_is_bkpt;
      // original flash fetch dropped on match
      fetch_discard <= fetch_hit_any;
      fetch_new_addr <= {remap_q[31:`PBU_REMAP_LO], fetch_idx, 2'h0};
      fetch_bkpt_instr <= fetch_hit_any & fetch_is_bkpt ? BKPT_OPCODE : 16'h0000;
      fetch_prot_addr <= fetch_valid ? fetch_addr : fetch_prot_addr;
      lit_remap <= lit_hit_any;
      // original flash load dropped on match
      lit_discard <= lit_hit_any;
      lit_new_addr <= {remap_q[31:`PBU_REMAP_LO], lit_idx, 2'h0};
      lit_prot_addr <= lit_valid ? lit_addr : lit_prot_addr;
    end
  end

  // Status: most recent matching comparator, a literal match beating a fetch match in the same cycle
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      last_idx_q <= 4'h0;
      last_bkpt_q <= 1'b0;
      last_any_q <= 1'b0;
    end else if (lit_hit_any) begin
      last_idx_q <= {1'b0, lit_idx};
      last_bkpt_q <= 1'b0;
      last_any_q <= 1'b1;
    end else if (fetch_hit_any) begin
      last_idx_q <= {1'b0, fetch_idx};
      last_bkpt_q <= fetch_is_bkpt;
      last_any_q <= 1'b1;
    end
  end

  // APB decode; zero wait states keep the master simple
  assign pready = 1'b1;
  assign wr_acc = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  assign comp_sel = (paddr >= `PBU_COMP_BASE_OFS) && (paddr <= `PBU_COMP_LAST_OFS) &&
                    (paddr[1:0] == 2'h0);
  assign comp_idx = paddr[4:2] - 3'h4;

  // Register writes take effect at the access edge
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= `PBU_CTRL_RST;
      remap_q <= `PBU_REMAP_RST;
      for (k = 0; k < N_COMP; k = k + 1) begin
        comp_q[k] <= `PBU_COMP_RST;
      end
    end else if (wr_acc) begin
      if (paddr == `PBU_CTRL_OFS) begin
        ctrl_q <= {31'h0, pwdata[`PBU_CTRL_GEN_BIT]};
      end
      if (paddr == `PBU_REMAP_OFS) begin
        remap_q <= {pwdata[31:`PBU_REMAP_LO], 5'h0};
      end
      if (comp_sel) begin
        comp_q[comp_idx] <= {3'h0, pwdata[`PBU_COMP_ADDR_HI:`PBU_COMP_ADDR_LO],
                             pwdata[`PBU_COMP_BKPT_BIT] & (comp_idx < N_INSTR),
                             pwdata[`PBU_COMP_EN_BIT]};
      end
    end
  end

  // Read mux; literal comparators read their breakpoint bit as zero
  always @* begin
    rd_mux = 32'h00000000;
    rd_err = 1'b0;
    if (paddr == `PBU_CTRL_OFS) begin
      rd_mux = ctrl_q;
    end else if (paddr == `PBU_STAT_OFS) begin
      rd_mux = {22'h0, last_any_q, last_bkpt_q, 4'h0, last_idx_q};
    end else if (paddr == `PBU_REMAP_OFS) begin
      rd_mux = remap_q;
    end else if (comp_sel) begin
      rd_mux = comp_q[comp_idx];
    end else begin
      rd_err = 1'b1;
    end
  end

  // Read data and error are captured in setup, stable through access
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (rd_setup) begin
      prdata <= pwrite ? 32'h00000000 : rd_mux;
      pslverr <= rd_err;
    end else if (!psel) begin
      pslverr <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* patch_breakpoint_unit_consts.vh */
// Purpose: Shared offsets, fields and reset values of the patch and breakpoint unit
// Assumes: 32-bit APB register bus, one word per register
// Notes: Included by the unit top and its comparator
`ifndef PATCH_BREAKPOINT_UNIT_CONSTS_VH
`define PATCH_BREAKPOINT_UNIT_CONSTS_VH

// Register byte offsets
`define PBU_CTRL_OFS 12'h000
`define PBU_STAT_OFS 12'h004
`define PBU_REMAP_OFS 12'h008
`define PBU_COMP_BASE_OFS 12'h010
`define PBU_COMP_LAST_OFS 12'h02C

// Control register fields
`define PBU_CTRL_GEN_BIT 0
// Comparator register fields
`define PBU_COMP_EN_BIT 0
`define PBU_COMP_BKPT_BIT 1
`define PBU_COMP_ADDR_HI 28
`define PBU_COMP_ADDR_LO 2
// Remap base holds bits 31..5, offsets fill bits 4..2
`define PBU_REMAP_LO 5

// Flash space is the low 512 MB
`define PBU_FLASH_TAG 3'h0

// Literal load sizes
`define PBU_SIZE_BYTE 2'h0
`define PBU_SIZE_HALF 2'h1
`define PBU_SIZE_WORD 2'h2

// Reset values
`define PBU_CTRL_RST 32'h00000000
`define PBU_REMAP_RST 32'h20000000
`define PBU_COMP_RST 32'h00000000

`endif

/* patch_compare.v */
// Purpose: One address comparator of the patch and breakpoint unit
// Assumes: Word-granular compare inside flash space
// Notes: Purely combinational, top registers the outcome
`timescale 1ns/1ps
`default_nettype none
`include "patch_breakpoint_unit_consts.vh"

module patch_compare (
  input wire global_en, // Unit-wide enable
  input wire [31:0] cfg, // Comparator register contents
  input wire [31:0] probe_addr, // Address under test
  input wire probe_valid, // Access present this cycle
  output wire hit // Comparator matched
);

  wire in_flash;
  wire addr_eq;

  // Only flash-space accesses are candidates
  assign in_flash = (probe_addr[31:29] == `PBU_FLASH_TAG);
  assign addr_eq = (probe_addr[`PBU_COMP_ADDR_HI:`PBU_COMP_ADDR_LO] ==
                    cfg[`PBU_COMP_ADDR_HI:`PBU_COMP_ADDR_LO]);

  assign hit = global_en & cfg[`PBU_COMP_EN_BIT] & probe_valid & in_flash & addr_eq;

endmodule
`default_nettype wire

/* pbu_checker.sv */
// Purpose: Port checker for the patch and breakpoint unit
// Assumes: One clock, async active-low reset
// Notes: Bound in from the testbench top
`timescale 1ns/1ps
`default_nettype none
module pbu_checker #(
  parameter [15:0] BKPT_OPCODE = 16'h0000 // Breakpoint code
) (
  input wire clk, // Clock
  input wire rst_b, // Reset, low
  input wire fetch_valid, // Fetch request
  input wire [31:0] fetch_addr, // Fetch address
  input wire lit_valid, // Literal request
  input wire [31:0] lit_addr, // Literal address
  input wire [1:0] lit_size, // Literal size
  input wire fetch_bkpt, // Breakpoint hit
  input wire fetch_discard, // Fetch dropped
  input wire [15:0] fetch_bkpt_instr, // Returned code
  input wire [31:0] fetch_prot_addr, // Fetch check address
  input wire lit_remap, // Literal remapped
  input wire lit_discard, // Literal dropped
  input wire [31:0] lit_new_addr, // Literal new address
  input wire [31:0] lit_prot_addr // Literal check address
);
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // Request steps seen by the unit
  sequence s_freq;
    fetch_valid;
  endsequence
  sequence s_bad_lit;
    lit_valid && lit_size == 2'h2 && lit_addr[1:0] != 2'h0;
  endsequence
  // Outcome ties back to its request
  AST_FPROT: assert property (s_freq |=> fetch_prot_addr == $past(fetch_addr))
    else $error("fetch check address wrong");
  AST_LPROT: assert property (lit_valid |=> lit_prot_addr == $past(lit_addr))
    else $error("literal check address wrong");
  AST_UNAL: assert property (s_bad_lit |=> !lit_remap && !lit_discard)
    else $error("unaligned literal remapped");
  AST_FLASH: assert property (s_freq ##0 fetch_addr[31:29] != 3'h0 |=> !fetch_discard)
    else $error("non-flash fetch matched");
  AST_FLAG: assert property (fetch_discard |-> $past(fetch_valid))
    else $error("fetch drop without request");
  AST_LADDR: assert property (lit_discard |-> lit_remap && lit_new_addr[4:3] == 2'h3)
    else $error("literal remap offset wrong");
  AST_BK: assert property (fetch_bkpt |-> fetch_discard && fetch_bkpt_instr == BKPT_OPCODE)
    else $error("breakpoint answer wrong");
  AST_LFLAG: assert property (lit_remap |-> $past(lit_valid) && lit_discard)
    else $error("literal remap without request");
endmodule
`default_nettype wire

/* core_model.sv */
// Purpose: Core side issuing fetches and literal loads
// Assumes: Outcome lands one cycle after the request
// Notes: Tasks start just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input wire logic clk, // Clock
  output var logic fetch_valid, // Fetch request
  output var logic [31:0] fetch_addr, // Fetch address
  output var logic lit_valid, // Literal request
  output var logic [31:0] lit_addr, // Literal address
  output var logic [1:0] lit_size, // Literal size
  input wire logic fetch_discard, // Drop flash fetch
  input wire logic [31:0] fetch_new_addr, // Redirect
  input wire logic lit_discard, // Drop flash load
  input wire logic [31:0] lit_new_addr // Redirect
);
  logic [31:0] eff; // Address the core really used
  // Idle requests from time zero
  initial begin
    fetch_valid = 1'b0;
    fetch_addr = 32'h0;
    lit_valid = 1'b0;
    lit_addr = 32'h0;
    lit_size = 2'h0;
  end
  task automatic fetch(input logic [31:0] a);
    fetch_valid <= 1'b1;
    fetch_addr <= a;
    @(posedge clk);
    fetch_valid <= 1'b0;
    @(posedge clk);
    eff = fetch_discard ? fetch_new_addr : a;
  endtask
  task automatic lit(input logic [31:0] a, input logic [1:0] s);
    lit_valid <= 1'b1;
    lit_addr <= a;
    lit_size <= s;
    @(posedge clk);
    lit_valid <= 1'b0;
    @(posedge clk);
    eff = lit_discard ? lit_new_addr : a;
  endtask
endmodule
`default_nettype wire

/* patch_breakpoint_unit_tb.sv */
// Purpose: Self-checking bench for the patch and breakpoint unit
// Assumes: Zero-wait APB slave, one-cycle match latency
// Notes: Comparators sit at 0x100 steps in flash
`timescale 1ns/1ps
`default_nettype none
`include "patch_breakpoint_unit_consts.vh"
`define CHK(g, x) begin tests_run++; if ((g) !== (x)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x); end end
module patch_breakpoint_unit_tb;
  localparam logic [15:0] BK = 16'hA5C3; // Arbitrary code
  logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, r;
  wire pready, pslverr, fetch_valid, lit_valid, fetch_remap, fetch_bkpt;
  wire fetch_discard, lit_remap, lit_discard;
  wire [31:0] prdata, fetch_addr, lit_addr, fetch_new_addr, fetch_prot_addr;
  wire [31:0] lit_new_addr, lit_prot_addr;
  wire [1:0] lit_size;
  wire [15:0] fetch_bkpt_instr;
  int n_fail = 0, tests_run = 0, i;
  // Free-running 8 ns clock
  always #4 clk = ~clk;
  patch_breakpoint_unit #(.BKPT_OPCODE(BK)) patch_breakpoint_unit_i (.clk(clk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr), .lit_valid(lit_valid), .lit_addr(lit_addr),
    .lit_size(lit_size), .fetch_remap(fetch_remap), .fetch_bkpt(fetch_bkpt),
    .fetch_discard(fetch_discard), .fetch_new_addr(fetch_new_addr),
    .fetch_bkpt_instr(fetch_bkpt_instr), .fetch_prot_addr(fetch_prot_addr),
    .lit_remap(lit_remap), .lit_discard(lit_discard), .lit_new_addr(lit_new_addr),
    .lit_prot_addr(lit_prot_addr));
  core_model core_model_i (.clk(clk), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
    .lit_valid(lit_valid), .lit_addr(lit_addr), .lit_size(lit_size),
    .fetch_discard(fetch_discard), .fetch_new_addr(fetch_new_addr),
    .lit_discard(lit_discard), .lit_new_addr(lit_new_addr));
  // Verdict and end of run
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One APB transfer; wait is bounded so a stuck slave ends the run
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin n_fail++; report_and_stop; end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    apb(0, `PBU_REMAP_OFS, 0);
    `CHK(r, 32'h20000000)
    apb(0, 12'hFFC, 0);
    `CHK(e, 1'b1)
    for (i = 0; i < 8; i++) begin
      apb(1, `PBU_COMP_BASE_OFS + 12'(4 * i), 32'h100 * (i + 1) + 1);
    end
    apb(0, `PBU_COMP_BASE_OFS + 12'h01C, 0);
    `CHK(r, 32'h00000801)
    apb(1, `PBU_REMAP_OFS, 32'h20001000);
    core_model_i.fetch(32'h100);
    `CHK(core_model_i.eff, 32'h100)
    apb(1, `PBU_CTRL_OFS, 1);
    apb(0, `PBU_CTRL_OFS, 0);
    `CHK(r, 32'h00000001)
    for (i = 0; i < 6; i++) begin
      core_model_i.fetch(32'h100 * (i + 1));
      `CHK(core_model_i.eff, 32'h20001000 + 4 * i)
      `CHK(fetch_remap, 1'b1)
      `CHK(fetch_prot_addr, 32'h100 * (i + 1))
    end
    for (i = 6; i < 8; i++) begin
      core_model_i.lit(32'h100 * (i + 1), `PBU_SIZE_WORD);
      `CHK(core_model_i.eff, 32'h20001000 + 4 * i)
      `CHK(lit_remap, 1'b1)
    end
    // Byte and aligned half inside the word still match, unaligned forms do not
    core_model_i.lit(32'h701, `PBU_SIZE_BYTE);
    `CHK(core_model_i.eff, 32'h20001018)
    core_model_i.lit(32'h702, `PBU_SIZE_HALF);
    `CHK(core_model_i.eff, 32'h20001018)
    core_model_i.lit(32'h700, 2'h3);
    `CHK(core_model_i.eff, 32'h700)
    core_model_i.lit(32'h702, `PBU_SIZE_WORD);
    `CHK(core_model_i.eff, 32'h702)
    `CHK(lit_remap, 1'b0)
    `CHK(lit_prot_addr, 32'h702)
    apb(1, `PBU_COMP_BASE_OFS + 12'h008, 32'h303);
    core_model_i.fetch(32'h300);
    `CHK(({fetch_bkpt, fetch_remap, fetch_bkpt_instr}), ({2'b10, BK}))
    apb(0, `PBU_STAT_OFS, 0);
    `CHK(r, 32'h00000302)
    apb(1, `PBU_COMP_BASE_OFS + 12'h00C, 32'h400);
    core_model_i.fetch(32'h400);
    `CHK(fetch_discard, 1'b0)
    core_model_i.fetch(32'h20000500);
    `CHK(fetch_discard, 1'b0)
    apb(1, `PBU_CTRL_OFS, 0);
    core_model_i.fetch(32'h600);
    `CHK(fetch_discard, 1'b0)
    report_and_stop;
  end
endmodule
bind patch_breakpoint_unit pbu_checker #(.BKPT_OPCODE(BKPT_OPCODE)) pbu_checker_i (
  .clk(clk), .rst_b(rst_b), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
  .lit_valid(lit_valid), .lit_addr(lit_addr), .lit_size(lit_size), .fetch_bkpt(fetch_bkpt),
  .fetch_discard(fetch_discard), .fetch_bkpt_instr(fetch_bkpt_instr),
  .fetch_prot_addr(fetch_prot_addr), .lit_remap(lit_remap), .lit_discard(lit_discard),
  .lit_new_addr(lit_new_addr), .lit_prot_addr(lit_prot_addr));
`default_nettype wire
